// >>> bench/tb_flash_self_program_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsp_consts.svh"
module tb_flash_self_program_ctrl;
  localparam int WC = 20;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, wb_dat_o;
  logic wb_ack_o, cpu_stall_o, ser_ok, mem_we_o;
  logic pwrt = 0, wp = 1, cp_on = 0, dp = 0;
  logic [12:0] mem_addr_o, last_a;
  logic [13:0] mem_wdata_o, last_wd, rdata = 0;
  int error_cnt = 0, tests_run = 0, we_cnt = 0, stall_cnt = 0, cyc_cnt = 0;

  fsp_ctrl #(.WRITE_CYCLES(WC)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwrt_done_i(pwrt),
    .program_write_protect_i(wp), .code_protect_on_i(cp_on), .data_protect_bit_i(dp),
    .cpu_stall_o(cpu_stall_o), .serial_access_ok_o(ser_ok), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(rdata));

  initial forever #4 clk_i = ~clk_i;

  // Registered outputs are watched mid-cycle, clear of the edge updates
  always @(negedge clk_i) begin
    if (mem_we_o === 1'b1) begin
      we_cnt++;
      last_a = mem_addr_o;
      last_wd = mem_wdata_o;
    end
    if (cpu_stall_o === 1'b1) stall_cnt++;
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task test_done;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ack and read data are taken at the rising edge; the request is let go there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n == 50) chk("ack", 0, 1);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic prog(input logic [7:0] en, input logic [7:0] k2, output logic done);
    logic [31:0] q;
    done = 0;
    wr(`FSP_OFF_CTRL, en);
    wr(`FSP_OFF_UNLOCK, 8'h55);
    wr(`FSP_OFF_UNLOCK, k2);
    wr(`FSP_OFF_CTRL, 8'h86);
    wr(`FSP_OFF_CTRL, 8'h80);
    for (int i = 0; i < 40 && !done; i++) begin
      rd(`FSP_OFF_STATUS, q);
      done = (q[0] === 1'b1);
    end
    wr(`FSP_OFF_STATUS, 8'h01);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    rd(`FSP_OFF_CTRL, q);
    chk("ctrl after reset", q, 32'h0);
    rd(8'h1c, q);
    chk("unmapped read", q, 32'h0);
    rd(`FSP_OFF_STATUS, q);
    chk("serial ok unprotected", {31'h0, q[3]}, 32'h1);
    we_cnt = 0;
    prog(8'h84, 8'haa, q[0]);
    chk("write before timer", we_cnt, 0);
    pwrt <= 1;
    repeat (4) @(posedge clk_i);
    $display("test reset done");
  endtask

  task automatic t_read;
    logic [31:0] q;
    cp_on <= 1;
    wr(`FSP_OFF_ADDR_LO, 8'h34);
    wr(`FSP_OFF_ADDR_HI, 8'h12);
    rdata <= 14'h2a5c;
    wr(`FSP_OFF_CTRL, 8'h81);
    chk("read address", mem_addr_o, 32'h1234);
    repeat (3) @(posedge clk_i);
    rdata <= 14'h0155;
    rd(`FSP_OFF_DATA_LO, q);
    chk("read low", q, 32'h5c);
    rd(`FSP_OFF_DATA_HI, q);
    chk("read high", q, 32'h2a);
    repeat (5) @(posedge clk_i);
    rd(`FSP_OFF_DATA_LO, q);
    chk("read low held", q, 32'h5c);
    cp_on <= 0;
    $display("test read done");
  endtask

  task automatic t_write;
    logic d;
    logic [31:0] q;
    wr(`FSP_OFF_ADDR_LO, 8'hbc);
    wr(`FSP_OFF_ADDR_HI, 8'h0a);
    wr(`FSP_OFF_DATA_LO, 8'he7);
    wr(`FSP_OFF_DATA_HI, 8'h3f);
    we_cnt = 0;
    stall_cnt = 0;
    prog(8'h84, 8'haa, d);
    chk("done flag", d, 1);
    chk("write pulses", we_cnt, 1);
    chk("write address", last_a, 32'h0abc);
    chk("write word", last_wd, 32'h3fe7);
    chk("stall length", stall_cnt, WC);
    rd(`FSP_OFF_CTRL, q);
    chk("strobe cleared", {31'h0, q[1]}, 0);
    rd(`FSP_OFF_STATUS, q);
    chk("done cleared", {31'h0, q[0]}, 0);
    $display("test write done");
  endtask

  // Same-op strobe, broken key order, and fuse-blocked write
  task automatic t_refuse;
    logic [7:0] en[3] = '{8'h80, 8'h84, 8'h84};
    logic [7:0] k2[3] = '{8'haa, 8'h55, 8'haa};
    logic wpv[3] = '{1'b1, 1'b1, 1'b0};
    logic d;
    for (int i = 0; i < 3; i++) begin
      wp <= wpv[i];
      repeat (4) @(posedge clk_i);
      we_cnt = 0;
      prog(en[i], k2[i], d);
      chk("refused write", we_cnt, 0);
      chk("refused done", d, !wpv[i]);
    end
    wp <= 1;
    $display("test refuse done");
  endtask

  task automatic t_serial;
    logic [31:0] q;
    cp_on <= 1;
    dp <= 0;
    repeat (5) @(posedge clk_i);
    chk("serial blocked", ser_ok, 0);
    rd(`FSP_OFF_STATUS, q);
    chk("serial status", {31'h0, q[3]}, 0);
    dp <= 1;
    repeat (5) @(posedge clk_i);
    chk("serial allowed", ser_ok, 1);
    cp_on <= 0;
    $display("test serial done");
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_read();
    t_write();
    t_refuse();
    t_serial();
    test_done();
  end
endmodule
`default_nettype wire

// >>> verilog/fsp_consts.svh
// Overview of operation
// - Read takes two cycles, then data valid
// - Data registers hold fetched word until changed
// - Write stalls CPU, peripherals keep running
// - Stall after second pad cycle, resume when array time ends
// - Write-protect bit zero blocks all writes
// - Strobe needs enable set earlier
// - Clearing enable does not abort write
// - Unlock 55h then AAh then strobe
// - Two setup cycles follow write strobe
// - Word is high and low data
// - End clears strobe, sets sticky done flag
// - No hardware verify of written value
// - Reset clears enable; timer inhibits writes
// - Data protect never blocks internal access
// - Protection with data-protect clear blocks serial
// - Internal reads never blocked by protection
// - Protection stays until full erase
// - Write-protect only via serial path
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH
`define FSP_OFF_CTRL 8'h00
`define FSP_OFF_UNLOCK 8'h04
`define FSP_OFF_ADDR_LO 8'h08
`define FSP_OFF_ADDR_HI 8'h0c
`define FSP_OFF_DATA_LO 8'h10
`define FSP_OFF_DATA_HI 8'h14
`define FSP_OFF_STATUS 8'h18
`define FSP_BIT_RD 0
`define FSP_BIT_WR 1
`define FSP_BIT_WRITE_ENABLE_BIT 2
`define FSP_BIT_PGSEL 7
`define FSP_BIT_DONE 0
`define FSP_BIT_STALL 1
`define FSP_BIT_PROT 2
`define FSP_BIT_SERIAL_OK 3
`define FSP_KEY1 8'h55
`define FSP_KEY2 8'haa
`define FSP_PAD_CYCLES 2
`define FSP_WRITE_TIME_US 8
`define FSP_CLK_MHZ 125
`define FSP_WRITE_CYCLES (`FSP_WRITE_TIME_US * `FSP_CLK_MHZ)
`endif

// >>> verilog/fsp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsp_consts.svh"
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int ADDR_W = 13,
  parameter int WRITE_CYCLES = `FSP_WRITE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pwrt_done_i,
  input wire logic program_write_protect_i,
  input wire logic code_protect_on_i,
  input wire logic data_protect_bit_i,
  output logic cpu_stall_o,
  output logic serial_access_ok_o,
  output logic mem_we_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [13:0] mem_wdata_o,
  input wire logic [13:0] mem_rdata_i
);
  fsp_state_t state;
  fsp_state_t next_state;
  fsp_unlock_t unlock;
  logic [7:0] address_low_reg;
  logic [7:0] address_high_reg;
  logic [7:0] data_low_reg;
  logic [5:0] data_high_reg;
  logic program_memory_select;
  logic write_enable_bit;
  logic write_strobe;
  logic write_done_flag;
  logic [1:0] pwrt_sync;
  logic [1:0] wp_sync;
  logic [1:0] cpon_sync;
  logic [1:0] cpd_sync;
  logic [1:0] pad_cnt;
  logic [31:0] busy_cnt;
  // Addresses are mapped for the full bus width so a wider array fits unchanged
  logic [15:0] full_addr;

  // Pins from the configuration fuses pass two flops before use
  always_ff @(posedge clk_i) begin
    pwrt_sync <= {pwrt_sync[0], pwrt_done_i};
    wp_sync <= {wp_sync[0], program_write_protect_i};
    cpon_sync <= {cpon_sync[0], code_protect_on_i};
    cpd_sync <= {cpd_sync[0], data_protect_bit_i};
  end

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = wb_adr_i == `FSP_OFF_CTRL;
  wire hit_unlock = wb_adr_i == `FSP_OFF_UNLOCK;
  wire hit_alo = wb_adr_i == `FSP_OFF_ADDR_LO;
  wire hit_ahi = wb_adr_i == `FSP_OFF_ADDR_HI;
  wire hit_dlo = wb_adr_i == `FSP_OFF_DATA_LO;
  wire hit_dhi = wb_adr_i == `FSP_OFF_DATA_HI;
  wire hit_stat = wb_adr_i == `FSP_OFF_STATUS;
  wire ctrl_wr = bus_wr & hit_ctrl;
  wire unlock_wr = bus_wr & hit_unlock;
  wire idle = state == FSP_IDLE;
  wire rd_req = ctrl_wr & wb_dat_i[`FSP_BIT_RD] & wb_dat_i[`FSP_BIT_PGSEL] & idle;
  // Strobe needs enable held from an earlier write plus full unlock
  wire wr_req = ctrl_wr & wb_dat_i[`FSP_BIT_WR] & write_enable_bit & idle
    & wb_dat_i[`FSP_BIT_PGSEL] & (unlock == FSP_UL_KEY2);
  // Fuse write-protect low or power-up timer running blocks the array write
  wire wr_allowed = wp_sync[1] & pwrt_sync[1];
  wire pad_end = pad_cnt == 2'(`FSP_PAD_CYCLES - 1);
  wire busy_end = busy_cnt == 32'(WRITE_CYCLES - 1);
  assign full_addr = {address_high_reg, address_low_reg};
  wire [ADDR_W-1:0] trunc_addr = full_addr[ADDR_W-1:0];
  wire [7:0] fetched_lo = mem_rdata_i[7:0];

  // A 55h write always restarts at the first key; any other bus write but the exact next key breaks the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock <= FSP_UL_NONE;
    end else if (unlock_wr && wb_dat_i[7:0] == `FSP_KEY1) begin
      unlock <= FSP_UL_KEY1;
    end else if (unlock_wr && wb_dat_i[7:0] == `FSP_KEY2 && unlock == FSP_UL_KEY1) begin
      unlock <= FSP_UL_KEY2;
    end else if (bus_wr) begin
      unlock <= FSP_UL_NONE;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      FSP_IDLE: begin
        if (rd_req) begin
          next_state = FSP_RD_PAD;
        end else if (wr_req) begin
          next_state = FSP_WR_PAD;
        end
      end
      FSP_RD_PAD: begin
        if (pad_end) begin
          next_state = FSP_IDLE;
        end
      end
      FSP_WR_PAD: begin
        if (pad_end) begin
          next_state = FSP_WR_BUSY;
        end
      end
      FSP_WR_BUSY: begin
        if (busy_end) begin
          next_state = FSP_WR_DONE;
        end
      end
      FSP_WR_DONE: next_state = FSP_IDLE;
      default: next_state = FSP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= FSP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || idle) begin
      pad_cnt <= 2'h0;
      busy_cnt <= 32'h0;
    end else begin
      pad_cnt <= pad_end ? 2'h0 : pad_cnt + 2'h1;
      busy_cnt <= (state == FSP_WR_BUSY) ? busy_cnt + 32'h1 : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_memory_select <= 1'b0;
      write_enable_bit <= 1'b0;
      write_strobe <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        program_memory_select <= wb_dat_i[`FSP_BIT_PGSEL];
        // Clearing enable mid-write leaves the strobe and state alone
        write_enable_bit <= wb_dat_i[`FSP_BIT_WRITE_ENABLE_BIT];
      end
      if (wr_req) begin
        write_strobe <= 1'b1;
      end else if (state == FSP_WR_DONE) begin
        write_strobe <= 1'b0;
      end
    end
  end

  // Done flag: hardware set wins over a software clear in the same cycle
  wire done_clr = bus_wr & hit_stat & wb_dat_i[`FSP_BIT_DONE];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_done_flag <= 1'b0;
    end else if (state == FSP_WR_DONE) begin
      write_done_flag <= 1'b1;
    end else if (done_clr) begin
      write_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      address_low_reg <= 8'h00;
      address_high_reg <= 8'h00;
    end else begin
      if (bus_wr && hit_alo) begin
        address_low_reg <= wb_dat_i[7:0];
      end
      if (bus_wr && hit_ahi) begin
        address_high_reg <= wb_dat_i[7:0];
      end
    end
  end

  // Fetched word is latched at the end of the pad; protection bits never gate it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_low_reg <= 8'h00;
      data_high_reg <= 6'h00;
    end else if (state == FSP_RD_PAD && pad_end) begin
      data_low_reg <= mem_rdata_i[7:0];
      data_high_reg <= mem_rdata_i[13:8];
    end else begin
      if (bus_wr && hit_dlo) begin
        data_low_reg <= wb_dat_i[7:0];
      end
      if (bus_wr && hit_dhi) begin
        data_high_reg <= wb_dat_i[5:0];
      end
    end
  end

  // One write pulse per word; no read-back compare is done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_we_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= 14'h0000;
    end else begin
      mem_we_o <= (state == FSP_WR_PAD) && pad_end && wr_allowed;
      mem_addr_o <= trunc_addr;
      mem_wdata_o <= {data_high_reg, data_low_reg};
    end
  end

  // Stall covers the array time only, not the pad slots; the core stalls after the second pad slot and resumes when the array time ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_stall_o <= 1'b0;
      serial_access_ok_o <= 1'b0;
    end else begin
      cpu_stall_o <= (next_state == FSP_WR_BUSY);
      // Fuse bits come from the array and clear only by bulk erase outside
      serial_access_ok_o <= ~(cpon_sync[1] & ~cpd_sync[1]);
    end
  end

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    if (hit_ctrl) begin
      rdata[`FSP_BIT_PGSEL] = program_memory_select;
      rdata[`FSP_BIT_WRITE_ENABLE_BIT] = write_enable_bit;
      rdata[`FSP_BIT_WR] = write_strobe;
      rdata[`FSP_BIT_RD] = state == FSP_RD_PAD;
    end else if (hit_alo) begin
      rdata[7:0] = address_low_reg;
    end else if (hit_ahi) begin
      rdata[7:0] = address_high_reg;
    end else if (hit_dlo) begin
      rdata[7:0] = data_low_reg;
    end else if (hit_dhi) begin
      rdata[5:0] = data_high_reg;
    end else if (hit_stat) begin
      rdata[`FSP_BIT_DONE] = write_done_flag;
      rdata[`FSP_BIT_STALL] = cpu_stall_o;
      rdata[`FSP_BIT_PROT] = ~wp_sync[1];
      rdata[`FSP_BIT_SERIAL_OK] = serial_access_ok_o;
    end
  end

  // Unlock reads zero; unmapped addresses ack with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rdata;
    end
  end

  chk_write_pulse_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_we_o |-> $past(wp_sync[1]) && $past(pwrt_sync[1])) else $error("write while protected");
  chk_strobe_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(write_strobe) |-> $past(write_enable_bit)) else $error("strobe without enable");
  sequence s_strobe;
    idle && wr_req;
  endsequence
  chk_pad_then_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    s_strobe |=> !cpu_stall_o [*2] ##1 cpu_stall_o) else $error("stall timing wrong");
  chk_done_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    state == FSP_WR_DONE |=> write_done_flag && !write_strobe) else $error("done not flagged");
  chk_read_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_req |=> state == FSP_RD_PAD [*2] ##1 idle) else $error("read pad length");
  chk_unlock_order: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_req |-> unlock == FSP_UL_KEY2) else $error("write without unlock");
  chk_no_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == FSP_WR_BUSY && !busy_end) |=> state == FSP_WR_BUSY) else $error("write aborted");
  chk_data_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle && !bus_wr) |=> $stable(data_low_reg)) else $error("data changed");
  chk_serial_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (cpon_sync[1] && !cpd_sync[1]) |=> !serial_access_ok_o) else $error("serial not blocked");

  // Helper count of held cycles, so a stuck stall is caught without long repetition
  logic [31:0] stall_run;
  always_ff @(posedge clk_i) begin
    if (rst_i || !cpu_stall_o) begin
      stall_run <= 32'h0;
    end else begin
      stall_run <= stall_run + 32'h1;
    end
  end

  sequence s_write_pad;
    state == FSP_WR_PAD [*2];
  endsequence

  sequence s_write_busy;
    state == FSP_WR_BUSY;
  endsequence

  sequence s_finish;
    state == FSP_WR_DONE ##1 idle;
  endsequence

  // Two pad slots come before the array time
  chk_write_path: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_req |=> s_write_pad ##1 s_write_busy)
    else $error("write path order");

  // Core is held no longer than the array write time
  chk_stall_bounded: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_stall_o |-> stall_run < 32'(WRITE_CYCLES))
    else $error("stall too long");

  // At most one array pulse per unlocked strobe
  chk_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_we_o |=> !mem_we_o)
    else $error("write pulse repeated");

  // Stored word pairs the two data registers
  chk_word_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_we_o |-> mem_wdata_o[7:0] == $past(data_low_reg)
      && mem_wdata_o[13:8] == $past(data_high_reg))
    else $error("write word mismatch");

  // Array address pairs the two address registers
  chk_addr_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_we_o |-> mem_addr_o == $past(trunc_addr))
    else $error("write address mismatch");

  // Enable starts cleared when reset is let go
  chk_write_enable_bit_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> !write_enable_bit)
    else $error("enable set after reset");

  // Core runs again once the write is over
  chk_resume_point: assert property (@(posedge clk_i) disable iff (rst_i)
    state == FSP_WR_DONE |-> !cpu_stall_o)
    else $error("stall held past done");

  // Strobe stays up through the array time whatever enable does
  chk_strobe_held: assert property (@(posedge clk_i) disable iff (rst_i)
    state == FSP_WR_BUSY |-> write_strobe)
    else $error("strobe dropped mid write");

  // Done flag only falls by a software clear
  chk_done_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (write_done_flag && !done_clr) |=> write_done_flag)
    else $error("done flag lost");

  // Strobe is never seen up while idle
  chk_strobe_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    idle |-> !write_strobe)
    else $error("strobe stuck");

  // Array time ends straight in done, with no verify phase
  chk_no_verify: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == FSP_WR_BUSY && busy_end) |=> s_finish)
    else $error("extra phase after write");

  // Fetched word is taken whatever the protection inputs say
  chk_fetch_open: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == FSP_RD_PAD && pad_end) |=> data_low_reg == $past(fetched_lo))
    else $error("fetch blocked");

  // No array pulse while a read is under way
  chk_read_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    state == FSP_RD_PAD |-> !mem_we_o)
    else $error("write during read");

  // Without code protection the serial path stays open
  chk_serial_open: assert property (@(posedge clk_i) disable iff (rst_i)
    !cpon_sync[1] |=> serial_access_ok_o)
    else $error("serial wrongly blocked");
endmodule
`default_nettype wire

// >>> verilog/fsp_pkg.sv
package fsp_pkg;
  typedef enum logic [2:0] {
    FSP_IDLE = 3'b000,
    FSP_RD_PAD = 3'b001,
    FSP_WR_PAD = 3'b011,
    FSP_WR_BUSY = 3'b010,
    FSP_WR_DONE = 3'b110
  } fsp_state_t;
  typedef enum logic [1:0] {
    FSP_UL_NONE = 2'b00,
    FSP_UL_KEY1 = 2'b01,
    FSP_UL_KEY2 = 2'b11
  } fsp_unlock_t;
endpackage
